// ### logic/lscr_top.sv
`timescale 1ns/1ns
module lscr_top (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// internal register port behind the serial host interface
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	output logic                            reg_rvalid,
	// measurement side
	input  wire logic [31:0]                mod_data0,
	input  wire logic [31:0]                mod_data1,
	input  wire logic [31:0]                mod_data2,
	input  wire logic                       digital_sat,
	input  wire logic                       analog_sat,
	input  wire logic [31:0]                light_low_threshold,
	input  wire logic [31:0]                light_high_threshold,
	input  wire logic                       light_done,
	input  wire logic                       flicker_busy,
	input  wire logic                       flicker_done,
	input  wire logic                       light_irq_clear,
	input  wire logic                       general_irq,
	input  wire logic                       sync_gpio_out,
	input  wire logic                       seq_step_done,
	input  wire logic                       seq_round_done,
	input  wire logic                       power_on_bit,
	input  wire logic                       trim_wr,
	input  wire logic [lscr_pkg::TRIM_W-1:0] trim_wdata,
	output logic                            fifo_wr,
	output logic      [31:0]                fifo_word,
	output logic      [1:0]                 light_word_format,
	output logic                            light_irq,
	output logic                            light_irq_status,
	output logic                            hysteresis_state_signal,
	output logic                            irq_pin,
	output logic                            sync_pin,
	output logic                            calib_trigger,
	output logic                            sequencer_system_irq,
	output logic      [1:0]                 gain_target_shift,
	output logic                            buffer_level_threshold_lsb,
	output logic      [lscr_pkg::TRIM_W-1:0] oscillator_trim
);
	import lscr_pkg::*;

	//==================================================================
	// helpers
	//==================================================================
	function automatic logic [31:0] pick_src(input logic [1:0] sel, input logic [31:0] d0,
		input logic [31:0] d1, input logic [31:0] d2);
		case (sel)
			SRC_MOD1: pick_src = d1;
			SRC_MOD2: pick_src = d2;
			default:  pick_src = d0;
		endcase
	endfunction : pick_src

	function automatic logic [31:0] fmt_word(input logic [1:0] fmt, input logic [31:0] d,
		input logic dsat, input logic asat);
		case (fmt)
			FMT_24:  fmt_word = dsat ? SAT24_DIG : (asat ? SAT24_ANA : {8'h00, d[23:0]});
			FMT_32:  fmt_word = dsat ? SAT32_DIG : (asat ? SAT32_ANA : d);
			default: fmt_word = {16'h0000, d[15:0]}; // reserved code falls back to 16-bit
		endcase
	endfunction : fmt_word

	// pin selection; codes 10 and 11 are never meant to be used, the pin idles low
	function automatic logic route_pin(input logic [1:0] rt, input logic normal,
		input logic hyst);
		case (rt)
			RT_NORMAL: route_pin = normal;
			RT_HYST:   route_pin = hyst;
			default:   route_pin = 1'b0;
		endcase
	endfunction : route_pin

	// writable bits of each register; unmapped offsets have none
	function automatic logic [7:0] live_bits(input logic [7:0] ad);
		case (ad)
			OFS_HOLD:   live_bits = MSK_HOLD;
			OFS_MODE:   live_bits = MSK_MODE;
			OFS_ROUTE:  live_bits = MSK_ROUTE;
			OFS_SEQFMT: live_bits = MSK_SEQFMT;
			OFS_THSRC:  live_bits = MSK_THSRC;
			default:    live_bits = 8'h00;
		endcase
	endfunction : live_bits

	//==================================================================
	// state
	//==================================================================
	logic [7:0]        r_hold, r_mode, r_route, r_seqfmt, r_thsrc;
	logic [7:0]        next_hold, next_mode, next_route, next_seqfmt, next_thsrc;
	logic [7:0]        next_rdata;
	logic              next_rvalid;
	logic              pend, next_pend;
	logic [31:0]       pend_word, next_pend_word;
	logic              next_fifo_wr;
	logic [31:0]       next_fifo_word;
	logic              next_light_irq, next_status, next_hyst;
	logic              next_irq_pin, next_sync_pin, next_calib, next_seq_irq;
	logic              power_on_q, next_power_on_q;
	logic [TRIM_W-1:0] next_trim;
	logic [31:0]       src;
	logic              above, below, crossing;

	// next values of registers, datapath and pins
	always_comb begin
		next_hold   = r_hold;
		next_mode   = r_mode;
		next_route  = r_route;
		next_seqfmt = r_seqfmt;
		next_thsrc  = r_thsrc;
		if (reg_wr) begin
			// reserved bits are masked away on write
			case (reg_addr)
				OFS_HOLD:   next_hold   = reg_wdata & MSK_HOLD;
				OFS_MODE:   next_mode   = reg_wdata & MSK_MODE;
				OFS_ROUTE:  next_route  = reg_wdata & MSK_ROUTE;
				OFS_SEQFMT: next_seqfmt = reg_wdata & MSK_SEQFMT;
				OFS_THSRC:  next_thsrc  = reg_wdata & MSK_THSRC;
				default:    ;
			endcase
		end
		next_rvalid = reg_rd;
		case (reg_addr)
			OFS_HOLD:   next_rdata = r_hold;
			OFS_MODE:   next_rdata = r_mode;
			OFS_ROUTE:  next_rdata = r_route;
			OFS_SEQFMT: next_rdata = r_seqfmt;
			OFS_THSRC:  next_rdata = r_thsrc;
			default:    next_rdata = 8'h00; // unmapped reads as zero
		endcase
		if (!reg_rd)
			next_rdata = reg_rdata;

		// threshold comparison on the selected channel
		src      = pick_src(r_thsrc[POS_THSRC +: 2], mod_data0, mod_data1, mod_data2);
		above    = src > light_high_threshold;
		below    = src < light_low_threshold;
		next_hyst = hysteresis_state_signal;
		if (light_done && above)
			next_hyst = 1'b1;
		else if (light_done && below)
			next_hyst = 1'b0;
		crossing = next_hyst != hysteresis_state_signal;
		if (r_mode[BIT_CROSS])
			next_light_irq = light_done && crossing;
		else
			next_light_irq = light_done && (above || below);
		// set wins over a clear arriving in the same cycle
		next_status = next_light_irq || (light_irq_status && !light_irq_clear);

		// fifo writes, possibly held back behind a long flicker measurement
		next_fifo_wr   = 1'b0;
		next_fifo_word = fifo_word;
		next_pend      = pend;
		next_pend_word = pend_word;
		if (light_done && flicker_busy) begin
			if (r_hold[BIT_HOLD]) begin
				next_pend      = 1'b1;
				next_pend_word = fmt_word(r_seqfmt[POS_FMT +: 2], src, digital_sat, analog_sat);
			end
		end else if (light_done) begin
			next_fifo_wr   = 1'b1;
			next_fifo_word = fmt_word(r_seqfmt[POS_FMT +: 2], src, digital_sat, analog_sat);
		end
		// a held sample is released once flicker finishes
		if (pend && flicker_done && !(light_done && flicker_busy)) begin
			next_pend      = 1'b0;
			next_fifo_wr   = 1'b1;
			next_fifo_word = pend_word;
		end

		// pins: crossing mode shows the light status instead of the normal source
		next_irq_pin  = route_pin(r_route[POS_IRQRT +: 2],
			r_mode[BIT_CROSS] ? next_status : general_irq, next_hyst);
		next_sync_pin = route_pin(r_route[POS_SYNCRT +: 2],
			r_mode[BIT_CROSS] ? next_status : sync_gpio_out, next_hyst);

		// sequencer-driven events
		next_calib   = r_seqfmt[BIT_CAL] ? seq_step_done : seq_round_done;
		next_seq_irq = r_seqfmt[BIT_STEPIRQ] ? seq_step_done : seq_round_done;

		// oscillator trim; a load in the same cycle as power-on rise wins
		next_power_on_q = power_on_bit;
		next_trim  = oscillator_trim;
		if (power_on_bit && !power_on_q && !r_seqfmt[BIT_KEEP])
			next_trim = '0;
		if (trim_wr)
			next_trim = trim_wdata;
	end

	// register stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r_hold                  <= RST_HOLD;
			r_mode                  <= RST_MODE;
			r_route                 <= RST_ROUTE;
			r_seqfmt                <= RST_SEQFMT;
			r_thsrc                 <= RST_THSRC;
			reg_rdata               <= 8'h00;
			reg_rvalid              <= 1'b0;
			pend                    <= 1'b0;
			pend_word               <= 32'h00000000;
			fifo_wr                 <= 1'b0;
			fifo_word               <= 32'h00000000;
			light_irq               <= 1'b0;
			light_irq_status        <= 1'b0;
			hysteresis_state_signal <= 1'b0;
			irq_pin                 <= 1'b0;
			sync_pin                <= 1'b0;
			calib_trigger           <= 1'b0;
			sequencer_system_irq    <= 1'b0;
			power_on_q              <= 1'b0;
			oscillator_trim         <= '0;
			light_word_format       <= 2'h0;
			gain_target_shift       <= SHIFT_HALF;
			buffer_level_threshold_lsb <= 1'b1;
		end else begin
			r_hold                  <= next_hold;
			r_mode                  <= next_mode;
			r_route                 <= next_route;
			r_seqfmt                <= next_seqfmt;
			r_thsrc                 <= next_thsrc;
			reg_rdata               <= next_rdata;
			reg_rvalid              <= next_rvalid;
			pend                    <= next_pend;
			pend_word               <= next_pend_word;
			fifo_wr                 <= next_fifo_wr;
			fifo_word               <= next_fifo_word;
			light_irq               <= next_light_irq;
			light_irq_status        <= next_status;
			hysteresis_state_signal <= next_hyst;
			irq_pin                 <= next_irq_pin;
			sync_pin                <= next_sync_pin;
			calib_trigger           <= next_calib;
			sequencer_system_irq    <= next_seq_irq;
			power_on_q              <= next_power_on_q;
			oscillator_trim         <= next_trim;
			light_word_format       <= next_seqfmt[POS_FMT +: 2];
			gain_target_shift       <= next_seqfmt[BIT_TARGET] ? SHIFT_QUARTER : SHIFT_HALF;
			buffer_level_threshold_lsb <= next_mode[BIT_THR_LSB];
		end
	end

	//==================================================================
	// checks
	//==================================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_drop_without_hold: assert property (
		light_done && flicker_busy && !r_hold[BIT_HOLD] && !(pend && flicker_done) |=> !fifo_wr)
		else $error("light result written during flicker without hold");
	a_release_on_flicker: assert property (
		pend && flicker_done && !(light_done && flicker_busy) |=> fifo_wr && fifo_word == $past(pend_word))
		else $error("held light result not released");
	a_cross_only_irq: assert property (
		r_mode[BIT_CROSS] && light_done && above && hysteresis_state_signal |=> !light_irq)
		else $error("crossing mode fired without a crossing");
	a_level_irq_out: assert property (
		!r_mode[BIT_CROSS] && light_done && below |=> light_irq)
		else $error("level mode missed out-of-range sample");
	a_hyst_route_pin: assert property (
		r_route[POS_IRQRT +: 2] == RT_HYST && !reg_wr |=> irq_pin == hysteresis_state_signal)
		else $error("irq pin does not follow hysteresis state");
	a_direct_sync_pin: assert property (
		r_mode[BIT_CROSS] && r_route[1:0] == RT_NORMAL && !reg_wr |=> sync_pin == light_irq_status)
		else $error("sync pin does not show light status");
	a_step_calib: assert property (
		r_seqfmt[BIT_CAL] && seq_step_done |=> calib_trigger)
		else $error("per-step calibration missing");
	a_round_seq_irq: assert property (
		!r_seqfmt[BIT_STEPIRQ] && !seq_round_done |=> !sequencer_system_irq)
		else $error("sequencer irq outside round end");
	a_trim_cleared: assert property (
		$rose(power_on_bit) && !r_seqfmt[BIT_KEEP] && !trim_wr |=> oscillator_trim == '0)
		else $error("trim not cleared at power-on rise");
	a_sat32_code: assert property (
		light_done && !flicker_busy && r_seqfmt[1:0] == FMT_32 && analog_sat && !digital_sat
		|=> fifo_word == SAT32_ANA)
		else $error("analog saturation code wrong");
	a_reserved_zero: assert property (
		reg_rd |=> (reg_rdata & ~live_bits($past(reg_addr))) == 8'h00)
		else $error("reserved bits read nonzero");

	c_held_write: cover property (pend ##[1:50] fifo_wr);
	c_cross_irq: cover property (r_mode[BIT_CROSS] && light_irq);
	c_trim_kept: cover property ($rose(power_on_bit) && r_seqfmt[BIT_KEEP]);
endmodule : lscr_top

// ### logic/lscr_pkg.sv
//==================================================================
// light sensor configuration register constants
//==================================================================
package lscr_pkg;
	// register offsets
	localparam logic [7:0] OFS_HOLD   = 8'hA2;
	localparam logic [7:0] OFS_MODE   = 8'hA3;
	localparam logic [7:0] OFS_ROUTE  = 8'hA4;
	localparam logic [7:0] OFS_SEQFMT = 8'hA5;
	localparam logic [7:0] OFS_THSRC  = 8'hA6;
	// writable bit masks; everything else is reserved
	localparam logic [7:0] MSK_HOLD   = 8'h04;
	localparam logic [7:0] MSK_MODE   = 8'h81;
	localparam logic [7:0] MSK_ROUTE  = 8'h33;
	localparam logic [7:0] MSK_SEQFMT = 8'h7B;
	localparam logic [7:0] MSK_THSRC  = 8'h30;
	// reset values
	localparam logic [7:0] RST_HOLD   = 8'h00;
	localparam logic [7:0] RST_MODE   = 8'h01;
	localparam logic [7:0] RST_ROUTE  = 8'h00;
	localparam logic [7:0] RST_SEQFMT = 8'h00;
	localparam logic [7:0] RST_THSRC  = 8'h00;
	// field positions
	localparam int BIT_HOLD    = 2;
	localparam int BIT_CROSS   = 7;
	localparam int BIT_THR_LSB = 0;
	localparam int BIT_CAL     = 6;
	localparam int BIT_TARGET  = 5;
	localparam int BIT_STEPIRQ = 4;
	localparam int BIT_KEEP    = 3;
	localparam int POS_IRQRT   = 4;
	localparam int POS_SYNCRT  = 0;
	localparam int POS_FMT     = 0;
	localparam int POS_THSRC   = 4;
	// field codes
	localparam logic [1:0] RT_NORMAL  = 2'h0;
	localparam logic [1:0] RT_HYST    = 2'h1;
	localparam logic [1:0] FMT_16     = 2'h0;
	localparam logic [1:0] FMT_24     = 2'h1;
	localparam logic [1:0] FMT_32     = 2'h3;
	localparam logic [1:0] SRC_MOD1   = 2'h1;
	localparam logic [1:0] SRC_MOD2   = 2'h2;
	// gain prediction target as a right shift of full scale
	localparam logic [1:0] SHIFT_HALF    = 2'h1;
	localparam logic [1:0] SHIFT_QUARTER = 2'h2;
	// saturation markers
	localparam logic [31:0] SAT24_DIG = 32'h00FFFFFF;
	localparam logic [31:0] SAT24_ANA = 32'h00FFFFFE;
	localparam logic [31:0] SAT32_DIG = 32'hFFFFFFFF;
	localparam logic [31:0] SAT32_ANA = 32'hFFFFFFFE;
	localparam int TRIM_W = 8;
endpackage : lscr_pkg

// ### sim/lscr_host_model.sv
`timescale 1ns/1ns
//==================================================================
// host side of the register byte port
//==================================================================
module lscr_host_model (
	input  wire logic       clock,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// callers pass route codes 00/01 only; no gain control here, so calibration bit is free
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d; // released data must not look valid
	endtask : wr
	// read strobe for one cycle, answer taken one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd
endmodule : lscr_host_model

// ### sim/tb_lscr_top.sv
`timescale 1ns/1ns
//==================================================================
// self-checking bench for the configuration register block
//==================================================================
module tb_lscr_top;
	import lscr_pkg::*;
	logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, digital_sat, analog_sat, light_done;
	logic flicker_busy, flicker_done, light_irq_clear, general_irq, sync_gpio_out;
	logic seq_step_done, seq_round_done, power_on_bit, trim_wr, fifo_wr, light_irq;
	logic light_irq_status, hysteresis_state_signal, irq_pin, sync_pin, calib_trigger;
	logic sequencer_system_irq, buffer_level_threshold_lsb;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, trim_wdata, oscillator_trim;
	logic [31:0] mod_data0, mod_data1, mod_data2, light_low_threshold, light_high_threshold;
	logic [31:0] fifo_word, d;
	logic [1:0]  light_word_format, gain_target_shift;
	logic [7:0]  a, cfg;
	logic [31:0] cd [5] = '{32'h2000, 32'h3000, 32'h800, 32'h10, 32'h20};
	logic [1:0]  fl [3] = '{FMT_16, FMT_24, FMT_32};
	int          fails = 0;
	int          tests_run = 0;
	lscr_top i_lscr_top (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_rvalid, .mod_data0, .mod_data1, .mod_data2, .digital_sat, .analog_sat,
		.light_low_threshold, .light_high_threshold, .light_done, .flicker_busy,
		.flicker_done, .light_irq_clear, .general_irq, .sync_gpio_out, .seq_step_done,
		.seq_round_done, .power_on_bit, .trim_wr, .trim_wdata, .fifo_wr, .fifo_word,
		.light_word_format, .light_irq, .light_irq_status, .hysteresis_state_signal,
		.irq_pin, .sync_pin, .calib_trigger, .sequencer_system_irq, .gain_target_shift,
		.buffer_level_threshold_lsb, .oscillator_trim);
	lscr_host_model i_lscr_host_model (.clock, .reg_rdata, .reg_rvalid, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd);
	always #4 clock = ~clock;
	//==================================================================
	// helpers
	//==================================================================
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick
	// one-cycle pulse; its registered effect is visible when this returns
	task automatic pulse(ref logic s);
		tick;
		s = 1'b1;
		tick;
		s = 1'b0;
	endtask : pulse
	task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
		logic [7:0] q;
		logic       v;
		i_lscr_host_model.rd(ad, q, v);
		chk("rvalid", 32'h1, {31'h0, v});
		chk("rdata", {24'h0, e}, {24'h0, q});
	endtask : rdc
	function automatic logic [7:0] msk(input logic [7:0] ad);
		case (ad)
			OFS_HOLD:   return MSK_HOLD;
			OFS_MODE:   return MSK_MODE;
			OFS_ROUTE:  return MSK_ROUTE;
			OFS_SEQFMT: return MSK_SEQFMT;
			OFS_THSRC:  return MSK_THSRC;
			default:    return 8'h00;
		endcase
	endfunction : msk
	// saturation markers only exist in the wide formats
	function automatic logic [31:0] exp_word(input logic [1:0] f, input logic [31:0] v,
		input logic dg, input logic an);
		if (f == FMT_24) return dg ? SAT24_DIG : an ? SAT24_ANA : {8'h00, v[23:0]};
		if (f == FMT_32) return dg ? SAT32_DIG : an ? SAT32_ANA : v;
		return {16'h0000, v[15:0]};
	endfunction : exp_word
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// watchdog: the whole sequence needs well under ten microseconds
	initial begin
		#50000;
		fails++;
		print_verdict;
	end
	//==================================================================
	// main sequence
	//==================================================================
	initial begin
		{clock, rst_n, digital_sat, analog_sat, light_done, flicker_busy, flicker_done} = 7'h00;
		{light_irq_clear, general_irq, sync_gpio_out, seq_step_done, seq_round_done} = 5'h00;
		{power_on_bit, trim_wr, trim_wdata, mod_data0, mod_data1, mod_data2} = 106'h0;
		{light_low_threshold, light_high_threshold} = 64'h0;
		void'($urandom(32'h7F07));
		repeat (16) @(posedge clock);
		#1;
		rst_n = 1'b1;
		rdc(OFS_HOLD, RST_HOLD);
		rdc(OFS_MODE, RST_MODE);
		rdc(OFS_ROUTE, RST_ROUTE);
		rdc(OFS_SEQFMT, RST_SEQFMT);
		chk("thr_lsb", 32'h1, {31'h0, buffer_level_threshold_lsb});
		chk("target", {30'h0, SHIFT_HALF}, {30'h0, gain_target_shift});
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			a = OFS_HOLD + 8'(i % 6);
			cfg = 8'($urandom) & 8'hDD;
			i_lscr_host_model.wr(a, cfg);
			rdc(a, cfg & msk(a));
		end
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			cfg = {1'b0, i[1], 1'($urandom), i[0], 4'h0};
			i_lscr_host_model.wr(OFS_SEQFMT, cfg);
			chk("target", cfg[5] ? SHIFT_QUARTER : SHIFT_HALF, {30'h0, gain_target_shift});
			pulse(seq_step_done);
			chk("calib", {31'h0, cfg[6]}, {31'h0, calib_trigger});
			chk("seq_irq", {31'h0, cfg[4]}, {31'h0, sequencer_system_irq});
			pulse(seq_round_done);
			chk("calib", {31'h0, !cfg[6]}, {31'h0, calib_trigger});
			chk("seq_irq", {31'h0, !cfg[4]}, {31'h0, sequencer_system_irq});
		end
		$display("test sequencer done");
		i_lscr_host_model.wr(OFS_THSRC, 8'h00);
		foreach (fl[f]) for (int s = 0; s < 3; s++) begin
			i_lscr_host_model.wr(OFS_SEQFMT, {6'h00, fl[f]});
			chk("format", {30'h0, fl[f]}, {30'h0, light_word_format});
			mod_data0 = $urandom;
			digital_sat = (s == 1);
			analog_sat = (s == 2);
			pulse(light_done);
			chk("fifo_wr", 32'h1, {31'h0, fifo_wr});
			chk("word", exp_word(fl[f], mod_data0, digital_sat, analog_sat), fifo_word);
		end
		{digital_sat, analog_sat} = 2'b00;
		for (int c = 0; c < 4; c++) begin
			i_lscr_host_model.wr(OFS_THSRC, 8'(c << 4));
			{mod_data0, mod_data1, mod_data2} = {$urandom, $urandom, $urandom};
			pulse(light_done);
			chk("source", c == 1 ? mod_data1 : c == 2 ? mod_data2 : mod_data0, fifo_word);
		end
		$display("test format done");
		for (int h = 0; h < 2; h++) begin
			i_lscr_host_model.wr(OFS_HOLD, 8'(h << 2));
			flicker_busy = 1'b1;
			mod_data0 = $urandom;
			pulse(light_done);
			chk("held_wr", 32'h0, {31'h0, fifo_wr});
			flicker_busy = 1'b0;
			pulse(flicker_done);
			chk("late_wr", h, {31'h0, fifo_wr});
			if (h == 1) chk("late_word", mod_data0, fifo_word);
		end
		$display("test hold done");
		light_low_threshold = 32'h100;
		light_high_threshold = 32'h1000;
		i_lscr_host_model.wr(OFS_MODE, 8'h00);
		// the register sweep may have left a hysteresis route behind
		i_lscr_host_model.wr(OFS_ROUTE, 8'h00);
		general_irq = 1'b1;
		foreach (cd[i]) begin
			mod_data0 = cd[i];
			pulse(light_done);
			chk("level_irq", {31'h0, i != 2}, {31'h0, light_irq});
		end
		chk("irq_pin", 32'h1, {31'h0, irq_pin});
		chk("sync_pin", 32'h0, {31'h0, sync_pin});
		general_irq = 1'b0;
		i_lscr_host_model.wr(OFS_MODE, 8'h80);
		pulse(light_irq_clear);
		foreach (cd[i]) begin
			mod_data0 = cd[i];
			pulse(light_done);
			chk("cross_irq", {31'h0, i == 0 || i == 3}, {31'h0, light_irq});
			chk("hyst", {31'h0, i < 3}, {31'h0, hysteresis_state_signal});
			chk("direct_pins", 32'h3, {30'h0, irq_pin, sync_pin});
			chk("status", 32'h1, {31'h0, light_irq_status});
		end
		i_lscr_host_model.wr(OFS_ROUTE, 8'h11);
		// pins pick up the new route one edge after the write lands
		tick;
		chk("hyst_pins", 32'h0, {30'h0, irq_pin, sync_pin});
		mod_data0 = 32'h2000;
		pulse(light_done);
		chk("hyst_pins", 32'h3, {30'h0, irq_pin, sync_pin});
		i_lscr_host_model.wr(OFS_ROUTE, 8'h00);
		pulse(light_irq_clear);
		tick;
		chk("cleared_pins", 32'h0, {30'h0, irq_pin, sync_pin});
		chk("cleared_status", 32'h0, {31'h0, light_irq_status});
		$display("test interrupt done");
		for (int k = 0; k < 2; k++) begin
			i_lscr_host_model.wr(OFS_SEQFMT, 8'(k << 3));
			trim_wdata = 8'($urandom) | 8'h01;
			pulse(trim_wr);
			chk("trim_load", {24'h0, trim_wdata}, {24'h0, oscillator_trim});
			power_on_bit = 1'b1;
			tick;
			tick;
			chk("trim_pon", k ? {24'h0, trim_wdata} : 32'h0, {24'h0, oscillator_trim});
			power_on_bit = 1'b0;
		end
		$display("test trim done");
		print_verdict;
	end
endmodule : tb_lscr_top
